//--- core/sdcd_regs.vh
`ifndef SDCD_REGS_VH
`define SDCD_REGS_VH

// switch level reading: a closed (ON) switch reads 0, OFF reads 1
`define SDCD_SW_ON          1'b0

// reset levels: pins read idle low, switches read OFF
`define SDCD_SYNC_RST_PIN   1'b0
`define SDCD_SYNC_RST_SW    1'b1
`define SDCD_PREV_RST       1'b1
`define SDCD_OUT_RST        1'b0
`define SDCD_CODE_RST       3'h7

// resolution decode: {family, c, b, a}, bit = 1 means OFF
`define SDCD_RES_W          9
`define SDCD_POS_W          32
`define SDCD_CUR_W          10

// microsteps per full step, family switch ON
`define SDCD_MS_2           9'h002
`define SDCD_MS_4           9'h004
`define SDCD_MS_8           9'h008
`define SDCD_MS_16          9'h010
`define SDCD_MS_32          9'h020
`define SDCD_MS_64          9'h040
`define SDCD_MS_128         9'h080
`define SDCD_MS_256         9'h100
// family switch OFF
`define SDCD_MS_5           9'h005
`define SDCD_MS_10          9'h00a
`define SDCD_MS_20          9'h014
`define SDCD_MS_25          9'h019
`define SDCD_MS_40          9'h028
`define SDCD_MS_50          9'h032
`define SDCD_MS_100         9'h064
`define SDCD_MS_200         9'h0c8

// peak phase current in units of 10 mA, codes 0..7
`define SDCD_CUR_0          10'h07e
`define SDCD_CUR_1          10'h0b4
`define SDCD_CUR_2          10'h0ec
`define SDCD_CUR_3          10'h124
`define SDCD_CUR_4          10'h15f
`define SDCD_CUR_5          10'h199
`define SDCD_CUR_6          10'h1d0
`define SDCD_CUR_7          10'h208

// one microstep per accepted step in the position counter
`define SDCD_POS_ONE        32'h0000_0001
`define SDCD_POS_ZERO       32'h0000_0000

`endif

//--- core/sdcd_step_dir_command_decoder.v
`include "sdcd_regs.vh"

module sdcd_step_dir_command_decoder (
    input  wire                     i_clk_sys,
    input  wire                     i_resetn,
    input  wire                     i_step_pulse_input,
    input  wire                     i_direction_input,
    input  wire                     i_drive_enable_input,
    input  wire                     i_enable_sourcing_type,
    input  wire                     i_pulse_mode_jumper,
    input  wire                     i_direction_invert_jumper,
    input  wire                     i_active_edge_jumper,
    input  wire                     i_current_select_bit0,
    input  wire                     i_current_select_bit1,
    input  wire                     i_current_select_bit2,
    input  wire                     i_resolution_select_a,
    input  wire                     i_resolution_select_b,
    input  wire                     i_resolution_select_c,
    input  wire                     i_resolution_family_select,
    output reg                      o_step_accept,
    output reg                      o_step_dir_ccw,
    output reg                      o_drive_enabled,
    output reg  [`SDCD_RES_W-1:0]   o_microsteps_per_step,
    output reg  [2:0]               o_current_code,
    output reg  [`SDCD_CUR_W-1:0]   o_peak_current_10ma,
    output reg  [`SDCD_POS_W-1:0]   o_position
);

    // pins and switches each pass two flip-flops before any logic reads them
    wire                    step_s;
    wire                    dir_s;
    wire                    ena_s;
    wire                    src_s;
    wire                    dbl_mode;   // 1 = double-pulse
    wire                    dir_inv;
    wire                    edge_hi;    // 1 = rising edge / high active
    wire                    cur0_s;
    wire                    cur1_s;
    wire                    cur2_s;
    wire                    res_a_s;
    wire                    res_b_s;
    wire                    res_c_s;
    wire                    res_fam_s;
    reg                     step_prev_r;
    reg                     ccw_prev_r;

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_PIN)) sdcd_sync2_step_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_step_pulse_input),
        .o_q       (step_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_PIN)) sdcd_sync2_dir_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_direction_input),
        .o_q       (dir_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_PIN)) sdcd_sync2_ena_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_drive_enable_input),
        .o_q       (ena_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_PIN)) sdcd_sync2_src_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_enable_sourcing_type),
        .o_q       (src_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_dbl_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_pulse_mode_jumper),
        .o_q       (dbl_mode)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_inv_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_direction_invert_jumper),
        .o_q       (dir_inv)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_edge_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_active_edge_jumper),
        .o_q       (edge_hi)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_cur0_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_current_select_bit0),
        .o_q       (cur0_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_cur1_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_current_select_bit1),
        .o_q       (cur1_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_cur2_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_current_select_bit2),
        .o_q       (cur2_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_res_a_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_resolution_select_a),
        .o_q       (res_a_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_res_b_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_resolution_select_b),
        .o_q       (res_b_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_res_c_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_resolution_select_c),
        .o_q       (res_c_s)
    );

    sdcd_sync2 #(.RST_VAL(`SDCD_SYNC_RST_SW)) sdcd_sync2_res_fam_i (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_resolution_family_select),
        .o_q       (res_fam_s)
    );

    wire [2:0]              cur_sel = {cur2_s, cur1_s, cur0_s};
    wire [3:0]              res_sel = {res_fam_s, res_c_s, res_b_s, res_a_s};

    // requests normalised so that 1 means active
    wire step_act = edge_hi ? step_s : ~step_s;
    wire ccw_act  = edge_hi ? dir_s : ~dir_s;

    // undriven optocoupler input floats high, which is the enabled level when src_s is low (disabled when high)
    wire enabled  = src_s ? ~ena_s : ena_s;

    reg                     step_nxt;
    reg                     ccw_nxt;
    reg [`SDCD_RES_W-1:0]   ms_nxt;
    reg [`SDCD_CUR_W-1:0]   cur_nxt;

    always @* begin
        step_nxt = 1'b0;
        ccw_nxt  = o_step_dir_ccw;
        if (dbl_mode) begin
            if (step_act && !step_prev_r) begin
                step_nxt = 1'b1;
                ccw_nxt  = 1'b0;
            end else if (ccw_act && !ccw_prev_r) begin
                step_nxt = 1'b1;
                ccw_nxt  = 1'b1;
            end
        end else begin
            step_nxt = step_act && !step_prev_r;
            ccw_nxt  = dir_s ^ dir_inv;
        end
        if (dbl_mode && step_nxt) begin
            ccw_nxt = ccw_nxt ^ dir_inv;
        end
        case (res_sel)                                // {family,c,b,a}, 1 = OFF
            4'b0000: ms_nxt = `SDCD_MS_2;
            4'b0001: ms_nxt = `SDCD_MS_4;
            4'b0011: ms_nxt = `SDCD_MS_8;
            4'b0010: ms_nxt = `SDCD_MS_16;
            4'b0100: ms_nxt = `SDCD_MS_32;
            4'b0101: ms_nxt = `SDCD_MS_64;
            4'b0111: ms_nxt = `SDCD_MS_128;
            4'b0110: ms_nxt = `SDCD_MS_256;
            4'b1000: ms_nxt = `SDCD_MS_5;
            4'b1001: ms_nxt = `SDCD_MS_10;
            4'b1011: ms_nxt = `SDCD_MS_20;
            4'b1010: ms_nxt = `SDCD_MS_25;
            4'b1100: ms_nxt = `SDCD_MS_40;
            4'b1101: ms_nxt = `SDCD_MS_50;
            4'b1110: ms_nxt = `SDCD_MS_100;
            default: ms_nxt = `SDCD_MS_200;
        endcase
        case (cur_sel)
            3'h0:    cur_nxt = `SDCD_CUR_0;
            3'h1:    cur_nxt = `SDCD_CUR_1;
            3'h2:    cur_nxt = `SDCD_CUR_2;
            3'h3:    cur_nxt = `SDCD_CUR_3;
            3'h4:    cur_nxt = `SDCD_CUR_4;
            3'h5:    cur_nxt = `SDCD_CUR_5;
            3'h6:    cur_nxt = `SDCD_CUR_6;
            default: cur_nxt = `SDCD_CUR_7;
        endcase
    end

    // trackers start at active, but the synchronisers reset the requests to idle, so a level already active at release still counts as a step
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            step_prev_r <= `SDCD_PREV_RST;
            ccw_prev_r  <= `SDCD_PREV_RST;
        end else begin
            step_prev_r <= step_act;
            ccw_prev_r  <= ccw_act;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_step_accept  <= `SDCD_OUT_RST;
            o_step_dir_ccw <= `SDCD_OUT_RST;
        end else begin
            o_step_accept  <= step_nxt & enabled;
            o_step_dir_ccw <= ccw_nxt;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_drive_enabled <= `SDCD_OUT_RST;
        end else begin
            o_drive_enabled <= enabled;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_microsteps_per_step <= `SDCD_MS_200;
            o_current_code        <= `SDCD_CODE_RST;
            o_peak_current_10ma   <= `SDCD_CUR_7;
        end else begin
            o_microsteps_per_step <= ms_nxt;
            o_current_code        <= cur_sel;
            o_peak_current_10ma   <= cur_nxt;
        end
    end

    // signed count: cw adds one microstep, ccw takes one away
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_position <= `SDCD_POS_ZERO;
        end else if (step_nxt && enabled) begin
            if (ccw_nxt) begin
                o_position <= o_position - `SDCD_POS_ONE;
            end else begin
                o_position <= o_position + `SDCD_POS_ONE;
            end
        end
    end

endmodule // sdcd_step_dir_command_decoder

module sdcd_sync2 #(
    parameter [0:0] RST_VAL = 1'b0
) (
    input  wire             i_clk_sys,
    input  wire             i_resetn,
    input  wire             i_d,
    output reg              o_q
);

    // first stage is read by the second stage only
    reg                     meta_r;

    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            meta_r <= RST_VAL;
            o_q    <= RST_VAL;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end

endmodule // sdcd_sync2

//--- sim/sdcd_properties.sv
module sdcd_checker (
    input wire logic        i_clk_sys,
    input wire logic        i_resetn,
    input wire logic        i_drive_enable_input,
    input wire logic        i_enable_sourcing_type,
    input wire logic        i_current_select_bit0,
    input wire logic        i_current_select_bit1,
    input wire logic        i_current_select_bit2,
    input wire logic        o_step_accept,
    input wire logic        o_step_dir_ccw,
    input wire logic        o_drive_enabled,
    input wire logic [2:0]  o_current_code,
    input wire logic [9:0]  o_peak_current_10ma,
    input wire logic [31:0] o_position
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [4:0] sv = {i_enable_sourcing_type, i_drive_enable_input, i_current_select_bit2,
                     i_current_select_bit1, i_current_select_bit0};
    reg  [2:0] up_r;
    always @(posedge i_clk_sys) up_r <= !i_resetn ? 3'h0 : up_r + {2'h0, up_r != 3'h7};
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // inputs held for the whole two-flop sync plus output stage
    sequence s_set;
        up_r > 3'h3 && $stable(sv) && $past(sv) == $past(sv, 2) && $past(sv, 2) == $past(sv, 3);
    endsequence
    a_accept_one_cycle: assert property (o_step_accept |=> !o_step_accept) else $error("accept too long");
    a_pos_cw_inc: assert property (o_step_accept && !o_step_dir_ccw |->
        o_position == $past(o_position) + 32'h1) else $error("cw count wrong");
    a_pos_ccw_dec: assert property (o_step_accept && o_step_dir_ccw |->
        o_position == $past(o_position) - 32'h1) else $error("ccw count wrong");
    a_pos_hold: assert property (!o_step_accept |-> $stable(o_position)) else $error("position moved");
    a_step_needs_enable: assert property (o_step_accept |-> o_drive_enabled) else $error("step while off");
    a_enable_level: assert property (s_set |-> o_drive_enabled ==
        (i_drive_enable_input ^ i_enable_sourcing_type)) else $error("enable level wrong");
    a_code_follow: assert property (s_set |-> o_current_code ==
        {i_current_select_bit2, i_current_select_bit1, i_current_select_bit0}) else $error("code wrong");
    a_current_ends: assert property ((o_current_code != 3'h0 || o_peak_current_10ma == 10'h07e)
        && (o_current_code != 3'h7 || o_peak_current_10ma == 10'h208)) else $error("current wrong");
endmodule // sdcd_checker

bind sdcd_step_dir_command_decoder sdcd_checker sdcd_checker_i (.*);

//--- sim/sdcd_ctrl_model.sv
module sdcd_ctrl_model (
    input  wire logic i_clk_sys,
    output logic      o_step,
    output logic      o_dir
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic idle(input logic act);
        o_step = !act;
        o_dir = !act;
    endtask
    // single mode: direction then step pulse; double mode: lvl picks the ccw line
    task automatic go(input logic dbl, input logic act, input logic lvl);
        if (!dbl) begin
            o_dir = lvl;
            repeat (500) @(negedge i_clk_sys);
        end
        if (dbl && lvl) o_dir = act;
        else o_step = act;
        repeat (160) @(negedge i_clk_sys);
        if (dbl && lvl) o_dir = !act;
        else o_step = !act;
        repeat (180) @(negedge i_clk_sys);
    endtask
endmodule // sdcd_ctrl_model

//--- sim/step_dir_command_decoder_tb.sv
module step_dir_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rstn = 0, en_v = 1, en_oe = 1, src = 0, dbl = 0, inv = 0, act = 1;
    logic [2:0]  cur = 3'h7;
    logic [3:0]  res = 4'hf;
    logic [31:0] p0, d0, d1;
    tri1         en_w;
    wire         step_w, dir_w, acc, ccw, ena;
    wire [8:0]   ms;
    wire [2:0]   code;
    wire [9:0]   ma;
    wire [31:0]  pos;
    int          n_mismatch = 0, n_tests = 0, cyc = 0, n_acc = 0, k;
    logic [8:0]  ms_t [16] = '{9'h002, 9'h004, 9'h010, 9'h008, 9'h020, 9'h040, 9'h100, 9'h080,
                               9'h005, 9'h00a, 9'h019, 9'h014, 9'h028, 9'h032, 9'h064, 9'h0c8};
    logic [9:0]  ma_t [8] = '{10'h07e, 10'h0b4, 10'h0ec, 10'h124, 10'h15f, 10'h199, 10'h1d0, 10'h208};
    assign en_w = en_oe ? en_v : 1'bz;
    always #5 clk = !clk;
    sdcd_step_dir_command_decoder sdcd_step_dir_command_decoder_i (.i_clk_sys(clk), .i_resetn(rstn),
        .i_step_pulse_input(step_w), .i_direction_input(dir_w), .i_drive_enable_input(en_w),
        .i_enable_sourcing_type(src), .i_pulse_mode_jumper(dbl), .i_direction_invert_jumper(inv),
        .i_active_edge_jumper(act), .i_current_select_bit0(cur[0]), .i_current_select_bit1(cur[1]),
        .i_current_select_bit2(cur[2]), .i_resolution_select_a(res[0]), .i_resolution_select_b(res[1]),
        .i_resolution_select_c(res[2]), .i_resolution_family_select(res[3]), .o_step_accept(acc),
        .o_step_dir_ccw(ccw), .o_drive_enabled(ena), .o_microsteps_per_step(ms), .o_current_code(code),
        .o_peak_current_10ma(ma), .o_position(pos));
    sdcd_ctrl_model sdcd_ctrl_model_i (.i_clk_sys(clk), .o_step(step_w), .o_dir(dir_w));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(negedge clk) begin
        cyc++;
        n_acc += acc;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    // mode changes happen while disabled so jumper moves cannot count as steps
    task automatic cfg(input logic d, input logic v, input logic a);
        en_v = 0;
        @(negedge clk);
        {dbl, inv, act} = {d, v, a};
        sdcd_ctrl_model_i.idle(a);
        repeat (8) @(negedge clk);
        en_v = 1;
        repeat (8) @(negedge clk);
    endtask
    task automatic step1(input logic lvl, output logic [31:0] d);
        k = n_acc;
        p0 = pos;
        sdcd_ctrl_model_i.go(dbl, act, lvl);
        d = pos - p0;
        chk(n_acc - k, {31'h0, en_v});
    endtask
    initial begin
        sdcd_ctrl_model_i.idle(1);
        repeat (5) @(negedge clk);
        chk(pos, 0);
        chk(ms, 9'h0c8);
        chk(ma, 10'h208);
        chk(code, 3'h7);
        chk(acc, 0);
        rstn = 1;
        for (int i = 0; i < 24; i++) begin
            if (i < 16) res = i[3:0];
            else cur = i[2:0];
            repeat (4) @(negedge clk);
            if (i < 16) chk(ms, ms_t[i]);
            else chk({code, ma}, {i[2:0], ma_t[i-16]});
        end
        for (int i = 0; i < 4; i++) begin
            {src, en_v} = i[1:0];
            repeat (4) @(negedge clk);
            chk(ena, src ^ en_v);
        end
        {src, en_oe} = 0;
        repeat (4) @(negedge clk);
        chk(ena, 1);
        en_oe = 1;
        cfg(0, 0, 1);
        step1(0, d0); chk(d0 * d0, 1);
        step1(1, d1); chk(d1, -d0);
        chk(ccw, 1);
        cfg(0, 1, 1);
        step1(0, d1); chk(d1, -d0);
        cfg(0, 0, 0);
        step1(0, d1); chk(d1, d0);
        en_v = 0;
        step1(0, d1); chk(d1, 0);
        for (int a = 0; a < 2; a++) begin
            cfg(1, 0, a[0]);
            step1(0, d1); chk(d1, 1);
            chk(ccw, 0);
            step1(1, d1); chk(d1, 32'hffff_ffff);
            chk(ccw, 1);
        end
        close_out();
    end
endmodule // step_dir_command_decoder_tb
